// ### rtl/sfc_pkg.sv
// Package with register map, field layouts and reset values of the SR-IOV capability block.
package sfc_pkg;
  localparam int unsigned NUM_VF_TOTAL = 6;
  localparam logic [7:0] VF_BASE_FN = 8'h40;
  localparam logic [7:0] VF_LAST_FN = 8'h45;
  localparam logic [7:0] PF0_FN = 8'h00;
  localparam logic [7:0] PF1_FN = 8'h01;
  localparam logic [7:0] PF1_OFFSET_BASE = 8'h3F;
  localparam int unsigned PAGE_SHIFT = 12;
  localparam logic [31:0] MIN_MEM_STD = 32'h0000_0080;
  localparam logic [31:0] MIN_MEM_LEGACY = 32'h0000_0010;
  localparam logic [15:0] VF_DEVICE_ID_RST = 16'h0000;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INTR = 8'h04;
  localparam logic [7:0] OFS_VFCNT = 8'h08;
  localparam logic [7:0] OFS_OFFSET = 8'h0C;
  localparam logic [7:0] OFS_PF0_ID = 8'h10;
  localparam logic [7:0] OFS_PF1_ID = 8'h14;
  localparam logic [7:0] OFS_PAGE0 = 8'h18;
  localparam logic [7:0] OFS_PAGE1 = 8'h1C;
  localparam logic [7:0] OFS_BAR0 = 8'h20;
  localparam logic [7:0] OFS_BAR1 = 8'h24;
  localparam logic [7:0] OFS_MSIX = 8'h28;
  localparam logic [7:0] OFS_PM = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_DECODE = 8'h34;
  localparam logic [7:0] OFS_FNMAP = 8'h38;
  // Control register fields.
  localparam int unsigned CTRL_ROOT_PORT = 0;
  localparam int unsigned CTRL_LEGACY = 1;
  localparam int unsigned CTRL_SRIOV_EN = 2;
  localparam int unsigned CTRL_FLR_EN = 3;
  localparam int unsigned CTRL_PF1_EN = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  localparam logic [31:0] PAGE_RST = 32'h0000_0553;
  // Per-BAR configuration byte: enable, io, is64, prefetch, size log2 in [7:4].
  localparam int unsigned BAR_EN = 0;
  localparam int unsigned BAR_IO = 1;
  localparam int unsigned BAR_64 = 2;
  localparam int unsigned BAR_PF = 3;
  localparam int unsigned NUM_BARS = 6;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : sfc_pkg

// ### rtl/sfc_top.sv
// SR-IOV function capability configuration block with an AHB-Lite register slave.
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - INTx messages only when enabled per function
// - Pin mapping none suppresses all legacy interrupts
// - MSI advertises vector count and optional masking
// - Six VFs at function numbers 64 to 69
// - VFs numbered consecutively, PF0 ones first
// - PF0 is function 0, PF1 function 1
// - First VF offset is first VF minus PF
// - PF0 offset is 64 when it owns VFs
// - PF1 offset is 63 plus PF0 VF count
// - Four-bit SR-IOV capability version per PF
// - Sixteen-bit VF device ID per PF
// - Page size bit n means 2^(n+12) bytes
// - SR-IOV capability absent in root port mode
// - 64-bit BAR consumes the following BAR
// - BAR claims only its own space type
// - IO BARs 32-bit, unprefetchable, legacy only
// - Non-legacy prefetchable BARs below BAR5 are 64-bit
// - Minimum memory range 128 or 16 bytes
// - MSI-X reports size, offset, lower BAR index
// - Wake only from supported wake states
// - Function reset only in endpoint, targeted only
module sfc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] intx_request,
  output logic [1:0] intx_message,
  input wire logic [1:0] wake_event,
  input wire logic [3:0] pf0_power_state,
  input wire logic [3:0] pf1_power_state,
  output logic [1:0] power_wake_request,
  input wire logic [1:0] flr_request,
  output logic [1:0] flr_active,
  input wire logic decode_valid,
  input wire logic decode_is_io,
  input wire logic [2:0] decode_bar,
  input wire logic [31:0] decode_offset,
  output logic decode_hit,
  output logic config_error
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] intr;
    logic [31:0] vfcnt;
    logic [31:0] pf0_id;
    logic [31:0] pf1_id;
    logic [31:0] page0;
    logic [31:0] page1;
    logic [47:0] bars;
    logic [31:0] msix;
    logic [31:0] pm;
    logic [31:0] rdata;
    logic [7:0] addr;
    logic wr_pend;
    logic rd_pend;
    logic [1:0] intx;
    logic [1:0] wake;
    logic [1:0] flr;
    logic hit;
    logic err;
    logic sticky;
    logic [1:0] rq_sync0;
    logic [1:0] rq_sync1;
    logic [1:0] rq_sync2;
    logic [1:0] wk_sync0;
    logic [1:0] wk_sync1;
    logic [1:0] wk_sync2;
    logic [1:0] fl_sync0;
    logic [1:0] fl_sync1;
    logic [1:0] fl_sync2;
    logic [1:0] fl_stable;
    logic [1:0] rq_stable;
    logic [1:0] wk_stable;
  } sfc_state_s;

  sfc_state_s state_r;
  sfc_state_s state_nxt;

  // Legality of one BAR given the device variant and the previous BAR.
  function automatic logic sfc_bar_ok(input logic [7:0] cfg, input logic prev_64,
                                      input logic legacy, input int unsigned idx);
    logic ok;
    ok = 1'b1;
    if (cfg[sfc_pkg::BAR_EN]) begin
      if (prev_64) ok = 1'b0;
      if (cfg[sfc_pkg::BAR_IO] && (!legacy || cfg[sfc_pkg::BAR_64] || cfg[sfc_pkg::BAR_PF])) begin
        ok = 1'b0;
      end
      if (!cfg[sfc_pkg::BAR_IO] && !legacy && cfg[sfc_pkg::BAR_PF] && !cfg[sfc_pkg::BAR_64]
          && idx != sfc_pkg::NUM_BARS - 1) begin
        ok = 1'b0;
      end
      if (cfg[sfc_pkg::BAR_64] && idx == sfc_pkg::NUM_BARS - 1) ok = 1'b0;
      if (!legacy && cfg[7:4] < 4'h7) ok = 1'b0;
      if (cfg[7:4] < 4'h4) ok = 1'b0;
    end
    return ok;
  endfunction : sfc_bar_ok

  logic [2:0] pf0_vfs;
  logic [2:0] pf1_vfs;
  logic [3:0] vf_sum;
  logic [7:0] pf0_off;
  logic [7:0] pf1_off;
  localparam int NUM_BAR_BITS = 6;
  logic sriov_on;
  logic bars_ok;
  logic [NUM_BAR_BITS-1:0] bar_ok_vec;
  logic [31:0] fnmap;

  assign pf0_vfs = state_r.vfcnt[2:0];
  assign pf1_vfs = state_r.vfcnt[10:8];
  assign vf_sum = {1'b0, pf0_vfs} + {1'b0, pf1_vfs};
  assign sriov_on = state_r.ctrl[sfc_pkg::CTRL_SRIOV_EN]
                    && !state_r.ctrl[sfc_pkg::CTRL_ROOT_PORT];
  // First VF numbers minus own PF number; PF0 sits at function 0 and PF1 at function 1.
  assign pf0_off = (pf0_vfs != 3'h0) ? sfc_pkg::VF_BASE_FN - sfc_pkg::PF0_FN
                                     : 8'h00;
  assign pf1_off = (pf1_vfs != 3'h0) ? sfc_pkg::PF1_OFFSET_BASE + {5'h00, pf0_vfs}
                                     : 8'h00;
  // PF1 VFs start right after PF0 VFs in the shared 64..69 range.
  assign fnmap = {8'h00, sfc_pkg::VF_LAST_FN, sfc_pkg::VF_BASE_FN + {5'h00, pf0_vfs},
                  sfc_pkg::VF_BASE_FN};

  for (genvar g = 0; g < NUM_BAR_BITS; g++) begin : g_bar
    if (g == 0) begin : g_first
      assign bar_ok_vec[g] = sfc_bar_ok(state_r.bars[7:0], 1'b0,
                                        state_r.ctrl[sfc_pkg::CTRL_LEGACY], g);
    end else begin : g_rest
      assign bar_ok_vec[g] = sfc_bar_ok(state_r.bars[g*8 +: 8],
                                        state_r.bars[(g-1)*8 + sfc_pkg::BAR_64] &&
                                        state_r.bars[(g-1)*8 + sfc_pkg::BAR_EN],
                                        state_r.ctrl[sfc_pkg::CTRL_LEGACY], g);
    end
  end
  assign bars_ok = &bar_ok_vec;

  always_comb begin
    logic [7:0] bcfg;
    logic [35:0] span;
    logic [3:0] pstate;
    state_nxt = state_r;
    bcfg = state_r.bars[{decode_bar, 3'h0} +: 8];
    span = 36'h1 << bcfg[7:4];
    pstate = 4'h0;
    // Three-stage synchronisers on the pin inputs; first stage feeds only the second.
    state_nxt.rq_sync0 = intx_request;
    state_nxt.rq_sync1 = state_r.rq_sync0;
    state_nxt.rq_sync2 = state_r.rq_sync1;
    state_nxt.wk_sync0 = wake_event;
    state_nxt.wk_sync1 = state_r.wk_sync0;
    state_nxt.wk_sync2 = state_r.wk_sync1;
    state_nxt.fl_sync0 = flr_request;
    state_nxt.fl_sync1 = state_r.fl_sync0;
    state_nxt.fl_sync2 = state_r.fl_sync1;
    for (int i = 0; i < 2; i++) begin
      if (state_r.rq_sync1[i] == state_r.rq_sync2[i]) state_nxt.rq_stable[i] = state_r.rq_sync2[i];
      if (state_r.wk_sync1[i] == state_r.wk_sync2[i]) state_nxt.wk_stable[i] = state_r.wk_sync2[i];
      if (state_r.fl_sync1[i] == state_r.fl_sync2[i]) state_nxt.fl_stable[i] = state_r.fl_sync2[i];
    end
    // Legacy interrupt: enable bit [0], pin mapping [2:1] where zero means none.
    for (int i = 0; i < 2; i++) begin
      state_nxt.intx[i] = state_r.rq_stable[i] && state_r.intr[i*8]
                          && (state_r.intr[i*8+1 +: 2] != 2'h0);
      pstate = (i == 0) ? pf0_power_state : pf1_power_state;
      state_nxt.wake[i] = state_r.wk_stable[i]
                          && ((state_r.pm[i*8 +: 4] & pstate) != 4'h0);
      state_nxt.flr[i] = state_r.fl_stable[i] && state_r.ctrl[sfc_pkg::CTRL_FLR_EN]
                         && !state_r.ctrl[sfc_pkg::CTRL_ROOT_PORT];
    end
    if (!state_r.ctrl[sfc_pkg::CTRL_PF1_EN]) begin
      state_nxt.intx[1] = 1'b0;
      state_nxt.wake[1] = 1'b0;
      state_nxt.flr[1] = 1'b0;
    end
    // BAR claim: type must match and offset inside the aperture.
    state_nxt.hit = decode_valid && bcfg[sfc_pkg::BAR_EN] && bar_ok_vec[decode_bar]
                    && (bcfg[sfc_pkg::BAR_IO] == decode_is_io)
                    && ({4'h0, decode_offset} < span) && (decode_bar < 3'h6);
    state_nxt.err = (vf_sum > 4'(sfc_pkg::NUM_VF_TOTAL)) || !bars_ok;
    if (state_nxt.err) state_nxt.sticky = 1'b1;
    // AHB-Lite data phase of a write.
    if (state_r.wr_pend) begin
      unique case (state_r.addr)
        sfc_pkg::OFS_CTRL: state_nxt.ctrl = hwdata;
        sfc_pkg::OFS_INTR: state_nxt.intr = hwdata;
        sfc_pkg::OFS_VFCNT: state_nxt.vfcnt = hwdata & 32'h0000_0707;
        sfc_pkg::OFS_PF0_ID: state_nxt.pf0_id = hwdata;
        sfc_pkg::OFS_PF1_ID: state_nxt.pf1_id = hwdata;
        sfc_pkg::OFS_PAGE0: state_nxt.page0 = hwdata;
        sfc_pkg::OFS_PAGE1: state_nxt.page1 = hwdata;
        sfc_pkg::OFS_BAR0: state_nxt.bars[31:0] = hwdata;
        sfc_pkg::OFS_BAR1: state_nxt.bars[47:32] = hwdata[15:0];
        sfc_pkg::OFS_MSIX: state_nxt.msix = hwdata;
        sfc_pkg::OFS_PM: state_nxt.pm = hwdata;
        // Writing one clears the sticky error, but a fresh error wins.
        sfc_pkg::OFS_STATUS: state_nxt.sticky = state_nxt.err | (state_r.sticky & ~hwdata[0]);
        default: ;
      endcase
    end
    state_nxt.wr_pend = 1'b0;
    state_nxt.rd_pend = 1'b0;
    if (hsel && hready && htrans == sfc_pkg::HTRANS_NONSEQ) begin
      state_nxt.addr = {haddr[7:2], 2'h0};
      state_nxt.wr_pend = hwrite;
      state_nxt.rd_pend = !hwrite;
    end
    if (state_nxt.rd_pend) begin
      unique case (state_nxt.addr)
        sfc_pkg::OFS_CTRL: state_nxt.rdata = state_r.ctrl;
        sfc_pkg::OFS_INTR: state_nxt.rdata = state_r.intr;
        sfc_pkg::OFS_VFCNT: state_nxt.rdata = state_r.vfcnt;
        sfc_pkg::OFS_OFFSET: begin
          state_nxt.rdata = sriov_on ? {16'h0000, pf1_off, pf0_off} : 32'h0;
        end
        sfc_pkg::OFS_PF0_ID: state_nxt.rdata = sriov_on ? state_r.pf0_id : 32'h0;
        sfc_pkg::OFS_PF1_ID: state_nxt.rdata = sriov_on ? state_r.pf1_id : 32'h0;
        sfc_pkg::OFS_PAGE0: state_nxt.rdata = sriov_on ? state_r.page0 : 32'h0;
        sfc_pkg::OFS_PAGE1: state_nxt.rdata = sriov_on ? state_r.page1 : 32'h0;
        sfc_pkg::OFS_BAR0: state_nxt.rdata = state_r.bars[31:0];
        sfc_pkg::OFS_BAR1: state_nxt.rdata = {16'h0000, state_r.bars[47:32]};
        sfc_pkg::OFS_MSIX: state_nxt.rdata = state_r.msix;
        sfc_pkg::OFS_PM: state_nxt.rdata = state_r.pm;
        sfc_pkg::OFS_STATUS: state_nxt.rdata = {18'h0_0000, bar_ok_vec, 2'h0, vf_sum,
                                                state_r.err, state_r.sticky};
        sfc_pkg::OFS_DECODE: state_nxt.rdata = {26'h0, bar_ok_vec};
        sfc_pkg::OFS_FNMAP: state_nxt.rdata = fnmap;
        default: state_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= '0;
      state_r.ctrl <= sfc_pkg::CTRL_RST;
      state_r.page0 <= sfc_pkg::PAGE_RST;
      state_r.page1 <= sfc_pkg::PAGE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign hrdata = state_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign intx_message = state_r.intx;
  assign power_wake_request = state_r.wake;
  assign flr_active = state_r.flr;
  assign decode_hit = state_r.hit;
  assign config_error = state_r.err;

  property p_intx_gate;
    @(posedge hclk) disable iff (!hresetn)
      intx_message[0] |-> $past(state_r.intr[0]) && $past(state_r.intr[2:1]) != 2'h0;
  endproperty
  a_intx_gate: assert property (p_intx_gate) else $error("INTx without enable");
  property p_pin_none;
    @(posedge hclk) disable iff (!hresetn)
      (state_r.intr[10:9] == 2'h0) [*2] |-> !intx_message[1];
  endproperty
  a_pin_none: assert property (p_pin_none) else $error("INTx with pin none");
  property p_pf0_off;
    @(posedge hclk) disable iff (!hresetn) (pf0_vfs != 3'h0) |-> pf0_off == 8'h40;
  endproperty
  a_pf0_off: assert property (p_pf0_off) else $error("PF0 offset wrong");
  property p_pf1_off;
    @(posedge hclk) disable iff (!hresetn)
      (pf1_vfs != 3'h0) |-> pf1_off == 8'h3F + {5'h00, pf0_vfs};
  endproperty
  a_pf1_off: assert property (p_pf1_off) else $error("PF1 offset wrong");
  property p_root_hide;
    @(posedge hclk) disable iff (!hresetn)
      state_r.ctrl[0] |-> !sriov_on;
  endproperty
  a_root_hide: assert property (p_root_hide) else $error("SR-IOV in root port");
  property p_hit_type;
    @(posedge hclk) disable iff (!hresetn)
      decode_hit |-> $past(decode_is_io) == $past(state_r.bars[{decode_bar, 3'h0} + 1]);
  endproperty
  a_hit_type: assert property (p_hit_type) else $error("BAR claimed wrong space");
  property p_wake;
    @(posedge hclk) disable iff (!hresetn)
      power_wake_request[0] |-> ($past(state_r.pm[3:0]) & $past(pf0_power_state)) != 4'h0;
  endproperty
  a_wake: assert property (p_wake) else $error("Wake from unsupported state");
  property p_flr;
    @(posedge hclk) disable iff (!hresetn)
      $past(state_r.ctrl[0]) |-> flr_active == 2'h0;
  endproperty
  a_flr: assert property (p_flr) else $error("Function reset in root port");
  property p_vf_sum;
    @(posedge hclk) disable iff (!hresetn)
      (vf_sum > 4'h6) |=> config_error;
  endproperty
  a_vf_sum: assert property (p_vf_sum) else $error("VF overflow not flagged");
  property p_sticky;
    @(posedge hclk) disable iff (!hresetn)
      config_error |-> state_r.sticky;
  endproperty
  a_sticky: assert property (p_sticky) else $error("Error not held sticky");
  property p_vf_order;
    @(posedge hclk) disable iff (!hresetn)
      (pf1_vfs != 3'h0) && (vf_sum <= 4'h6)
      |-> fnmap[15:8] + {5'h00, pf1_vfs} - 8'h01 <= fnmap[23:16];
  endproperty
  a_vf_order: assert property (p_vf_order) else $error("PF1 VFs leave the range");
  property p_flr_off;
    @(posedge hclk) disable iff (!hresetn)
      !state_r.ctrl[sfc_pkg::CTRL_FLR_EN] |=> flr_active == 2'h0;
  endproperty
  a_flr_off: assert property (p_flr_off) else $error("Function reset while off");
  property p_hit_bar;
    @(posedge hclk) disable iff (!hresetn)
      decode_hit |-> $past(decode_valid) && ($past(decode_bar) < 3'h6);
  endproperty
  a_hit_bar: assert property (p_hit_bar) else $error("Claim without valid BAR");
  property p_root_read;
    @(posedge hclk) disable iff (!hresetn)
      state_r.rd_pend && (state_r.addr == sfc_pkg::OFS_OFFSET)
      && $past(state_r.ctrl[sfc_pkg::CTRL_ROOT_PORT]) |-> hrdata == 32'h0;
  endproperty
  a_root_read: assert property (p_root_read) else $error("Offset seen in root port");
  property p_wake1;
    @(posedge hclk) disable iff (!hresetn)
      power_wake_request[1] |-> ($past(state_r.pm[11:8]) & $past(pf1_power_state)) != 4'h0;
  endproperty
  a_wake1: assert property (p_wake1) else $error("PF1 wake from unsupported state");
  property p_intx1;
    @(posedge hclk) disable iff (!hresetn)
      intx_message[1] |-> $past(state_r.intr[8]) && $past(state_r.ctrl[sfc_pkg::CTRL_PF1_EN]);
  endproperty
  a_intx1: assert property (p_intx1) else $error("PF1 INTx without enable");
endmodule : sfc_top

// ### tb/sfc_host_model.sv
// Host-side AHB-Lite master standing for the configuration software.
`timescale 1ns/1ps
module sfc_host_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // The data bus shows the inverse of its last value once released, so a slave that
  // samples late sees wrong data rather than a lucky match.
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h0, addr};
    htrans <= sfc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge hclk); while (hready !== 1'h1);
    rdata = hrdata;
    hwdata <= ~wdata;
  endtask : xfer
endmodule : sfc_host_model

// ### tb/tb.sv
// Self-checking testbench of the SR-IOV capability block.
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, decode_valid, decode_is_io;
  logic decode_hit, config_error;
  logic [31:0] haddr, hwdata, hrdata, decode_offset;
  logic [1:0] htrans, intx_request, intx_message, wake_event, power_wake_request;
  logic [1:0] flr_request, flr_active;
  logic [2:0] hsize, decode_bar;
  logic [3:0] pf0_power_state, pf1_power_state;
  int bad_count;
  int check_count;
  sfc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .intx_request(intx_request),
    .intx_message(intx_message), .wake_event(wake_event),
    .pf0_power_state(pf0_power_state), .pf1_power_state(pf1_power_state),
    .power_wake_request(power_wake_request), .flr_request(flr_request),
    .flr_active(flr_active), .decode_valid(decode_valid), .decode_is_io(decode_is_io),
    .decode_bar(decode_bar), .decode_offset(decode_offset), .decode_hit(decode_hit),
    .config_error(config_error));
  sfc_host_model host_u (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  always #2.5 hclk = ~hclk;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host_u.xfer(1'h1, a, d, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    host_u.xfer(1'h0, a, 32'h0, r);
    check(r, exp);
  endtask : rd_chk
  // Pin paths pass five flops, so outputs are judged after six cycles.
  task automatic settle;
    repeat (6) @(posedge hclk);
  endtask : settle
  task automatic decode(input logic io, input logic [2:0] bar, input logic [31:0] ofs,
                        input logic exp);
    @(posedge hclk);
    decode_valid <= 1'h1;
    decode_is_io <= io;
    decode_bar <= bar;
    decode_offset <= ofs;
    @(posedge hclk);
    decode_valid <= 1'h0;
    #1 check(decode_hit, exp);
  endtask : decode
  task automatic t_reset;
    check({hresp, intx_message, flr_active, power_wake_request, config_error}, 0);
    rd_chk(sfc_pkg::OFS_CTRL, sfc_pkg::CTRL_RST);
    rd_chk(sfc_pkg::OFS_PAGE0, sfc_pkg::PAGE_RST);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd_chk(8'hFC, 32'h0);
    wr(sfc_pkg::OFS_CTRL, 32'h0000_0014);
  endtask : t_reset
  task automatic t_offsets;
    logic [7:0] o0, o1;
    for (int n = 0; n <= 6; n++) begin
      o0 = (n > 0) ? 8'h40 : 8'h00;
      o1 = (n < 6) ? 8'h3F + 8'(n) : 8'h00;
      wr(sfc_pkg::OFS_VFCNT, {21'h0, 3'(6 - n), 5'h0, 3'(n)});
      rd_chk(sfc_pkg::OFS_OFFSET, {16'h0, o1, o0});
      if (n < 6) rd_chk(sfc_pkg::OFS_FNMAP, {8'h0, 8'h45, 8'h40 + 8'(n), 8'h40});
      settle;
      check(config_error, 1'h0);
    end
    wr(sfc_pkg::OFS_VFCNT, 32'h0000_0304);
    settle;
    check(config_error, 1'h1);
    wr(sfc_pkg::OFS_STATUS, 32'h0000_0001);
    rd_chk(sfc_pkg::OFS_STATUS, 32'h0000_3F1F);
    wr(sfc_pkg::OFS_VFCNT, 32'h0000_0202);
    wr(sfc_pkg::OFS_STATUS, 32'h0000_0001);
    rd_chk(sfc_pkg::OFS_STATUS, 32'h0000_3F10);
    wr(sfc_pkg::OFS_CTRL, 32'h0000_0015);
    rd_chk(sfc_pkg::OFS_OFFSET, 32'h0);
    wr(sfc_pkg::OFS_CTRL, 32'h0000_0014);
    rd_chk(sfc_pkg::OFS_OFFSET, 32'h0000_4140);
  endtask : t_offsets
  task automatic t_fields;
    wr(sfc_pkg::OFS_PF0_ID, 32'hABCD_0003);
    wr(sfc_pkg::OFS_PF1_ID, 32'h1234_000F);
    wr(sfc_pkg::OFS_PAGE1, 32'h8000_0001);
    wr(sfc_pkg::OFS_MSIX, 32'h0123_4567);
    rd_chk(sfc_pkg::OFS_PF0_ID, 32'hABCD_0003);
    rd_chk(sfc_pkg::OFS_PF1_ID, 32'h1234_000F);
    rd_chk(sfc_pkg::OFS_PAGE1, 32'h8000_0001);
    rd_chk(sfc_pkg::OFS_MSIX, 32'h0123_4567);
  endtask : t_fields
  task automatic t_pins;
    wr(sfc_pkg::OFS_INTR, 32'h0000_0103);
    intx_request <= 2'h3;
    settle;
    check(intx_message, 2'h1);
    wr(sfc_pkg::OFS_INTR, 32'h0000_0302);
    settle;
    check(intx_message, 2'h2);
    wr(sfc_pkg::OFS_PM, 32'h0000_0108);
    pf0_power_state <= 4'h8;
    pf1_power_state <= 4'h8;
    wake_event <= 2'h3;
    settle;
    check(power_wake_request, 2'h1);
    pf1_power_state <= 4'h1;
    settle;
    check(power_wake_request, 2'h3);
    wr(sfc_pkg::OFS_CTRL, 32'h0000_001C);
    flr_request <= 2'h2;
    settle;
    check(flr_active, 2'h2);
    wr(sfc_pkg::OFS_CTRL, 32'h0000_0014);
    settle;
    check(flr_active, 2'h0);
  endtask : t_pins
  task automatic t_bars;
    wr(sfc_pkg::OFS_BAR0, 32'h0000_0071);
    // The host keeps the vector table in its own memory behind memory BAR0.
    wr(sfc_pkg::OFS_MSIX, 32'h0000_0800);
    rd_chk(sfc_pkg::OFS_MSIX, 32'h0000_0800);
    decode(1'h0, 3'h0, 32'h0000_007C, 1'h1);
    decode(1'h1, 3'h0, 32'h0000_0010, 1'h0);
    decode(1'h0, 3'h0, 32'h0000_0080, 1'h0);
    wr(sfc_pkg::OFS_BAR0, 32'h0000_0079);
    settle;
    check(config_error, 1'h1);
    rd_chk(sfc_pkg::OFS_DECODE, 32'h0000_003E);
    wr(sfc_pkg::OFS_BAR0, 32'h0000_717D);
    settle;
    check(config_error, 1'h1);
    decode(1'h0, 3'h1, 32'h0000_0010, 1'h0);
    wr(sfc_pkg::OFS_BAR0, 32'h0000_007D);
    settle;
    check(config_error, 1'h0);
    decode(1'h0, 3'h0, 32'h0000_0040, 1'h1);
    wr(sfc_pkg::OFS_BAR0, 32'h0000_0073);
    settle;
    check(config_error, 1'h1);
    wr(sfc_pkg::OFS_BAR0, 32'h0000_0061);
    settle;
    check(config_error, 1'h1);
    wr(sfc_pkg::OFS_CTRL, 32'h0000_0016);
    settle;
    check(config_error, 1'h0);
  endtask : t_bars
  // A reset in mid-run must restore the reset values and silence the pin paths.
  task automatic t_mid_reset;
    @(posedge hclk);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    check({intx_message, flr_active, power_wake_request, config_error, decode_hit}, 32'h0);
    hresetn <= 1'h1;
    rd_chk(sfc_pkg::OFS_CTRL, sfc_pkg::CTRL_RST);
    rd_chk(sfc_pkg::OFS_OFFSET, 32'h0);
    settle;
    check({intx_message, power_wake_request, flr_active}, 32'h0);
  endtask : t_mid_reset
  initial begin
    hclk = 1'h0;
    hresetn = 1'h0;
    intx_request = 2'h0;
    wake_event = 2'h0;
    pf0_power_state = 4'h1;
    pf1_power_state = 4'h1;
    flr_request = 2'h0;
    decode_valid = 1'h0;
    decode_is_io = 1'h0;
    decode_bar = 3'h0;
    decode_offset = 32'h0;
    bad_count = 0;
    check_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset;
    t_offsets;
    t_fields;
    t_pins;
    t_bars;
    t_mid_reset;
    stop_test;
  end
  // The tests need about 320 cycles; twenty thousand means a hang.
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
endmodule : tb
